// File: hw/complement_compare_bit_ops_pkg.sv
package complement_compare_bit_ops_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int RAM_DEPTH = 16;
	localparam int RAM_IDX_W = 4;
	localparam int BIT_IDX_W = 3;
	localparam int FLAG_W = 4;

	// Register map, one register per address
	localparam logic [ADDR_W-1:0] ADDR_WORKING = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_PORT_DATA = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_PORT_DIR = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_PIN = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_RAM_BASE = 5'h10;

	// Field positions in the flag register
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_HALF = 2;
	localparam int FLAG_SIGNED = 3;

	// Reset values, and the single-bit constant that bit masks are shifted from
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_NOT_WORK = 4'h1,
		OP_NOT_MEM = 4'h2,
		OP_NEG_WORK = 4'h3,
		OP_NEG_MEM = 4'h4,
		OP_CMP_AM = 4'h5,
		OP_CMP_MA = 4'h6,
		OP_CLR_IO = 4'h7,
		OP_SET_IO = 4'h8,
		OP_CLR_MEM = 4'h9,
		OP_SET_MEM = 4'hA,
		OP_CARRY_XCHG = 4'hB
	} op_t;

endpackage

// File: hw/complement_compare_bit_ops.sv
`timescale 1ns/1ps
`default_nettype none

module complement_compare_bit_ops
	import complement_compare_bit_ops_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 ce,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [DATA_W-1:0]    wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output var  logic [DATA_W-1:0]    rdata,
	input  wire logic                 op_valid,
	input  wire logic [3:0]           op_code,
	input  wire logic [RAM_IDX_W-1:0] op_addr,
	input  wire logic [BIT_IDX_W-1:0] op_bit,
	output var  logic                 op_done,
	input  wire logic [DATA_W-1:0]    pin_in,
	output var  logic [DATA_W-1:0]    pin_out,
	output var  logic [DATA_W-1:0]    pin_oe
);

	function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IDX_W-1:0] n);
		bit_mask = ONE_BYTE << n;
	endfunction

	function automatic logic is_op(input logic [3:0] code, input op_t want);
		is_op = (code == want);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [DATA_W-1:0] working_register;
	logic [FLAG_W-1:0] flags;
	logic [DATA_W-1:0] port_a_data_reg;
	logic [DATA_W-1:0] port_dir;
	logic [DATA_W-1:0] pin_meta;
	logic [DATA_W-1:0] pin_sync;
	logic [DATA_W-1:0] ram [RAM_DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// Operation decode

	logic              op_fire;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] mem_val;
	logic              op_not_work;
	logic              op_not_mem;
	logic              op_neg_work;
	logic              op_neg_mem;
	logic              op_cmp_am;
	logic              op_cmp_ma;
	logic              op_clr_io;
	logic              op_set_io;
	logic              op_clr_mem;
	logic              op_set_mem;
	logic              op_carry_xchg;
	logic              op_cmp;

	assign op_fire = ce & op_valid;
	assign mask = bit_mask(op_bit);
	assign mem_val = ram[op_addr];
	assign op_not_work = op_fire & is_op(op_code, OP_NOT_WORK);
	assign op_not_mem = op_fire & is_op(op_code, OP_NOT_MEM);
	assign op_neg_work = op_fire & is_op(op_code, OP_NEG_WORK);
	assign op_neg_mem = op_fire & is_op(op_code, OP_NEG_MEM);
	assign op_cmp_am = op_fire & is_op(op_code, OP_CMP_AM);
	assign op_cmp_ma = op_fire & is_op(op_code, OP_CMP_MA);
	assign op_clr_io = op_fire & is_op(op_code, OP_CLR_IO);
	assign op_set_io = op_fire & is_op(op_code, OP_SET_IO);
	assign op_clr_mem = op_fire & is_op(op_code, OP_CLR_MEM);
	assign op_set_mem = op_fire & is_op(op_code, OP_SET_MEM);
	assign op_carry_xchg = op_fire & is_op(op_code, OP_CARRY_XCHG);
	assign op_cmp = op_cmp_am | op_cmp_ma;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic              bus_wr;
	logic              wr_work;
	logic              wr_flags;
	logic              wr_pdata;
	logic              wr_dir;
	logic              addr_ram;
	logic [DATA_W-1:0] read_mux;

	assign bus_wr = ce & wr;
	assign wr_work = bus_wr & (addr == ADDR_WORKING);
	assign wr_flags = bus_wr & (addr == ADDR_FLAGS);
	assign wr_pdata = bus_wr & (addr == ADDR_PORT_DATA);
	assign wr_dir = bus_wr & (addr == ADDR_PORT_DIR);
	assign addr_ram = (addr[ADDR_W-1:RAM_IDX_W] == ADDR_RAM_BASE[ADDR_W-1:RAM_IDX_W]);

	// Unmapped addresses read as zero
	assign read_mux = addr_ram                 ? ram[addr[RAM_IDX_W-1:0]] :
	                  (addr == ADDR_WORKING)   ? working_register :
	                  (addr == ADDR_FLAGS)     ? {{(DATA_W-FLAG_W){1'b0}}, flags} :
	                  (addr == ADDR_PORT_DATA) ? port_a_data_reg :
	                  (addr == ADDR_PORT_DIR)  ? port_dir :
	                  (addr == ADDR_PIN)       ? pin_sync : RST_BYTE;

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic

	logic [DATA_W-1:0] cmp_a;
	logic [DATA_W-1:0] cmp_b;
	logic [DATA_W:0]   cmp_diff;
	logic              cmp_borrow;
	logic              cmp_half;
	logic              cmp_range;
	logic              cmp_zero;
	logic [DATA_W-1:0] neg_work;
	logic [DATA_W-1:0] neg_mem;

	assign cmp_a = op_cmp_ma ? mem_val : working_register;
	assign cmp_b = op_cmp_ma ? working_register : mem_val;
	assign cmp_diff = {1'b0, cmp_a} - {1'b0, cmp_b};
	assign cmp_borrow = cmp_diff[DATA_W];
	assign cmp_half = (cmp_a[3:0] < cmp_b[3:0]);
	assign cmp_range = (cmp_a[DATA_W-1] != cmp_b[DATA_W-1]) &
	                   (cmp_diff[DATA_W-1] != cmp_a[DATA_W-1]);
	assign cmp_zero = (cmp_diff[DATA_W-1:0] == RST_BYTE);
	assign neg_work = RST_BYTE - working_register;
	assign neg_mem = RST_BYTE - mem_val;

	////////////////////////////////////////////////////////////////////////////
	// Next values

	logic              work_op_wr;
	logic [DATA_W-1:0] work_res;
	logic [DATA_W-1:0] next_working_register;
	logic              z_upd;
	logic              z_val;
	logic              swap_in;
	logic              swap_out;
	logic [FLAG_W-1:0] flags_base;
	logic [FLAG_W-1:0] next_flags;
	logic [DATA_W-1:0] pdata_base;
	logic [DATA_W-1:0] next_port_a_data_reg;
	logic [DATA_W-1:0] next_port_dir;
	logic              mem_op_wr;
	logic [DATA_W-1:0] mem_res;

	assign work_op_wr = op_not_work | op_neg_work;
	assign work_res = op_not_work ? ~working_register : neg_work;
	// An operation wins over a bus write to the same register
	assign next_working_register = work_op_wr ? work_res : wr_work ? wdata : working_register;

	assign z_upd = op_not_work | op_not_mem | op_neg_work | op_neg_mem | op_cmp;
	assign z_val = op_cmp ? cmp_zero :
	               work_op_wr ? (work_res == RST_BYTE) : (mem_res == RST_BYTE);
	assign swap_in = op_carry_xchg & ~port_dir[op_bit];
	assign swap_out = op_carry_xchg & port_dir[op_bit];

	assign flags_base = wr_flags ? wdata[FLAG_W-1:0] : flags;
	assign next_flags[FLAG_Z] = z_upd ? z_val : flags_base[FLAG_Z];
	assign next_flags[FLAG_C] = op_cmp ? cmp_borrow : swap_in ? pin_sync[op_bit] :
	                            flags_base[FLAG_C];
	assign next_flags[FLAG_HALF] = op_cmp ? cmp_half : flags_base[FLAG_HALF];
	assign next_flags[FLAG_SIGNED] = op_cmp ? cmp_range : flags_base[FLAG_SIGNED];

	assign pdata_base = wr_pdata ? wdata : port_a_data_reg;
	assign next_port_a_data_reg =
		op_clr_io ? (pdata_base & ~mask) :
		op_set_io ? (pdata_base | mask) :
		swap_out ? ((pdata_base & ~mask) | (flags[FLAG_C] ? mask : RST_BYTE)) :
		pdata_base;
	assign next_port_dir = wr_dir ? wdata : port_dir;

	assign mem_op_wr = op_not_mem | op_neg_mem | op_clr_mem | op_set_mem;
	assign mem_res = op_not_mem ? ~mem_val :
	                 op_neg_mem ? neg_mem :
	                 op_clr_mem ? (mem_val & ~mask) :
	                 (mem_val | mask);

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			working_register <= RST_BYTE;
			flags <= RST_FLAGS;
			port_a_data_reg <= RST_BYTE;
			port_dir <= RST_BYTE;
		end else if (ce) begin
			working_register <= next_working_register;
			flags <= next_flags;
			port_a_data_reg <= next_port_a_data_reg;
			port_dir <= next_port_dir;
		end
	end

	// Pins come from outside the clock domain
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta <= RST_BYTE;
			pin_sync <= RST_BYTE;
		end else if (ce) begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= RST_BYTE;
			op_done <= 1'b0;
			pin_out <= RST_BYTE;
			pin_oe <= RST_BYTE;
		end else if (ce) begin
			rdata <= rd ? read_mux : RST_BYTE;
			op_done <= op_valid;
			pin_out <= next_port_a_data_reg;
			pin_oe <= next_port_dir;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < RAM_DEPTH; gi++) begin : g_ram
			logic hit_op;
			logic hit_bus;
			assign hit_op = mem_op_wr & (op_addr == RAM_IDX_W'(gi));
			assign hit_bus = bus_wr & addr_ram & (addr[RAM_IDX_W-1:0] == RAM_IDX_W'(gi));
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					ram[gi] <= RST_BYTE;
				end else if (hit_op) begin
					ram[gi] <= mem_res;
				end else if (hit_bus) begin
					ram[gi] <= wdata;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	AST_NOT_WORK: assert property (
		op_not_work |=> working_register == ~$past(working_register)
			&& flags[FLAG_SIGNED:FLAG_C] == $past(flags[FLAG_SIGNED:FLAG_C])
	) else $error("not on working register wrong");

	AST_NEG_WORK: assert property (
		op_neg_work |=> (working_register + $past(working_register)) == RST_BYTE
			&& flags[FLAG_Z] == (working_register == RST_BYTE)
	) else $error("neg on working register wrong");

	AST_NEG_MEM: assert property (
		op_neg_mem |=> (ram[$past(op_addr)] + $past(mem_val)) == RST_BYTE
			&& flags[FLAG_C] == $past(flags[FLAG_C])
			&& flags[FLAG_SIGNED] == $past(flags[FLAG_SIGNED])
	) else $error("neg on ram byte wrong");

	AST_CMP_AM: assert property (
		op_cmp_am |=> flags[FLAG_C] == ($past(working_register) < $past(mem_val))
			&& flags[FLAG_Z] == ($past(working_register) == $past(mem_val))
			&& working_register == $past(working_register)
	) else $error("compare working-first wrong");

	AST_CMP_MA: assert property (
		op_cmp_ma |=> flags[FLAG_C] == ($past(mem_val) < $past(working_register))
			&& ram[$past(op_addr)] == $past(mem_val)
	) else $error("compare ram-first wrong");

	AST_CLR_IO: assert property (
		op_clr_io && !wr_pdata |=> port_a_data_reg == ($past(port_a_data_reg) & ~$past(mask))
			&& flags == $past(flags)
	) else $error("port bit clear wrong");

	AST_SET_IO: assert property (
		op_set_io && !wr_pdata |=> port_a_data_reg == ($past(port_a_data_reg) | $past(mask))
			&& flags == $past(flags)
	) else $error("port bit set wrong");

	AST_CLR_MEM: assert property (
		op_clr_mem |=> ram[$past(op_addr)] == ($past(mem_val) & ~$past(mask))
			&& flags == $past(flags)
	) else $error("ram bit clear wrong");

	AST_SET_MEM: assert property (
		op_set_mem |=> ram[$past(op_addr)] == ($past(mem_val) | $past(mask))
	) else $error("ram bit set wrong");

	AST_SWAP_OUT: assert property (
		swap_out |=> port_a_data_reg[$past(op_bit)] == $past(flags[FLAG_C])
			&& flags == $past(flags)
	) else $error("carry to output bit wrong");

	AST_SWAP_IN: assert property (
		swap_in |=> flags[FLAG_C] == $past(pin_sync[op_bit])
			&& {flags[FLAG_SIGNED], flags[FLAG_HALF], flags[FLAG_Z]} ==
			   $past({flags[FLAG_SIGNED], flags[FLAG_HALF], flags[FLAG_Z]})
	) else $error("pin to carry wrong");

	AST_DIR_PIN: assert property (
		wr_dir |=> pin_oe == $past(wdata) && port_dir == $past(wdata)
	) else $error("direction register not on pins");

endmodule // complement_compare_bit_ops

`default_nettype wire

// File: dv/pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Port pins: a driven pin shows its output, an undriven one the outside level
module pin_model
	import complement_compare_bit_ops_pkg::*;
(
	input  wire logic [DATA_W-1:0] pin_out,
	input  wire logic [DATA_W-1:0] pin_oe,
	input  wire logic [DATA_W-1:0] ext,
	output var  logic [DATA_W-1:0] pin_in
);
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pin_model

`default_nettype wire

// File: dv/tb_complement_compare_bit_ops.sv
`timescale 1ns/1ps
`default_nettype none

module tb_complement_compare_bit_ops
	import complement_compare_bit_ops_pkg::*;
;
	typedef struct {
		op_t        op;
		logic [3:0] ra;
		logic [2:0] bn;
		logic [7:0] wk, mem;
		logic [3:0] fl;
		logic [7:0] e_wk, e_mem;
		logic [3:0] e_fl;
	} row_t;

	logic                 clk, arst_n, ce, wr, rd, op_valid;
	logic [ADDR_W-1:0]    addr, loc;
	logic [DATA_W-1:0]    wdata, ext;
	logic [3:0]           op_code;
	logic [RAM_IDX_W-1:0] op_addr;
	logic [BIT_IDX_W-1:0] op_bit;
	wire logic [DATA_W-1:0] rdata, pin_in, pin_out, pin_oe;
	wire logic            op_done;
	int                   n_fail, cmp_count;
	row_t                 rows[14];
	row_t                 r;

	complement_compare_bit_ops dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_done(op_done),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Strobe left high so back-to-back writes need no second assignment
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
	endtask

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		wr <= 1'b0;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(name, rdata, e);
		@(posedge clk);
	endtask

	task automatic run_op(input op_t o, input logic [3:0] a, input logic [2:0] b);
		wr <= 1'b0;
		op_valid <= 1'b1;
		op_code <= o;
		op_addr <= a;
		op_bit <= b;
		@(posedge clk);
		op_valid <= 1'b0;
		#1 chk("op_done", {7'h00, op_done}, 8'h01);
		@(posedge clk);
		#1 chk("op_done low", {7'h00, op_done}, 8'h00);
	endtask

	task automatic idle(input int n);
		wr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 4000);
		n_fail++;
		stop_test();
	end

	initial begin
		rows[0] = '{OP_NOT_WORK, 4'h0, 3'h0, 8'h38, 8'h11, 4'hF, 8'hC7, 8'h11, 4'hE};
		rows[1] = '{OP_NOT_MEM, 4'hF, 3'h0, 8'h22, 8'hFF, 4'h0, 8'h22, 8'h00, 4'h1};
		rows[2] = '{OP_NEG_WORK, 4'h0, 3'h0, 8'h38, 8'h33, 4'hE, 8'hC8, 8'h33, 4'hE};
		rows[3] = '{OP_NEG_WORK, 4'h1, 3'h0, 8'h00, 8'h44, 4'h6, 8'h00, 8'h44, 4'h7};
		rows[4] = '{OP_NEG_MEM, 4'h7, 3'h0, 8'h55, 8'h01, 4'hB, 8'h55, 8'hFF, 4'hA};
		rows[5] = '{OP_CMP_AM, 4'h3, 3'h0, 8'h38, 8'h38, 4'hE, 8'h38, 8'h38, 4'h1};
		rows[6] = '{OP_CMP_AM, 4'h3, 3'h0, 8'h38, 8'h42, 4'h1, 8'h38, 8'h42, 4'h2};
		rows[7] = '{OP_CMP_MA, 4'h4, 3'h0, 8'h01, 8'h80, 4'h1, 8'h01, 8'h80, 4'hC};
		rows[8] = '{OP_CMP_MA, 4'h4, 3'h0, 8'h42, 8'h38, 4'h0, 8'h42, 8'h38, 4'h2};
		rows[9] = '{OP_CLR_IO, 4'h0, 3'h5, 8'h12, 8'hFF, 4'hF, 8'h12, 8'hDF, 4'hF};
		rows[10] = '{OP_SET_IO, 4'h0, 3'h0, 8'h12, 8'h00, 4'h0, 8'h12, 8'h01, 4'h0};
		rows[11] = '{OP_CLR_MEM, 4'h9, 3'h7, 8'h12, 8'hFF, 4'h5, 8'h12, 8'h7F, 4'h5};
		rows[12] = '{OP_SET_MEM, 4'hC, 3'h3, 8'h12, 8'h00, 4'hA, 8'h12, 8'h08, 4'hA};
		rows[13] = '{OP_NOP, 4'h2, 3'h1, 8'h55, 8'hAA, 4'h3, 8'h55, 8'hAA, 4'h3};
		{arst_n, wr, rd, op_valid, op_code, op_addr, op_bit} = '0;
		addr = '0;
		wdata = '0;
		ext = '0;
		ce = 1'b1;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_chk("reset work", ADDR_WORKING, RST_BYTE);
		rd_chk("reset flags", ADDR_FLAGS, {4'h0, RST_FLAGS});
		rd_chk("reset dir", ADDR_PORT_DIR, RST_BYTE);
		#1 chk("reset oe", pin_oe, RST_BYTE);
		foreach (rows[i]) begin
			r = rows[i];
			loc = (r.op == OP_CLR_IO || r.op == OP_SET_IO) ? ADDR_PORT_DATA : {1'b1, r.ra};
			wr_reg(ADDR_WORKING, r.wk);
			wr_reg(loc, r.mem);
			wr_reg(ADDR_FLAGS, {4'h0, r.fl});
			run_op(r.op, r.ra, r.bn);
			rd_chk("work", ADDR_WORKING, r.e_wk);
			rd_chk("target", loc, r.e_mem);
			rd_chk("flags", ADDR_FLAGS, {4'h0, r.e_fl});
			if (loc == ADDR_PORT_DATA)
				#1 chk("pin_out", pin_out, r.e_mem);
		end
		// Carry to an output pin, both carry levels
		wr_reg(ADDR_PORT_DIR, 8'h01);
		wr_reg(ADDR_PORT_DATA, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h02);
		run_op(OP_CARRY_XCHG, 4'h0, 3'h0);
		chk("out pin", pin_out, 8'h01);
		chk("oe", pin_oe, 8'h01);
		wr_reg(ADDR_FLAGS, 8'h00);
		run_op(OP_CARRY_XCHG, 4'h0, 3'h0);
		chk("out pin", pin_out, 8'h00);
		// Pin to carry on an input pin; sync needs two edges
		ext <= 8'h04;
		wr_reg(ADDR_PORT_DIR, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h09);
		idle(3);
		run_op(OP_CARRY_XCHG, 4'h0, 3'h2);
		rd_chk("flags in", ADDR_FLAGS, 8'h0B);
		rd_chk("pins", ADDR_PIN, 8'h04);
		ext <= 8'h00;
		wr_reg(ADDR_FLAGS, 8'h0F);
		idle(3);
		run_op(OP_CARRY_XCHG, 4'h0, 3'h2);
		rd_chk("flags in", ADDR_FLAGS, 8'h0D);
		rd_chk("port kept", ADDR_PORT_DATA, 8'h00);
		// Enable low freezes both a bus write and an operation
		ce <= 1'b0;
		wr_reg(ADDR_WORKING, 8'hA5);
		wr <= 1'b0;
		op_valid <= 1'b1;
		op_code <= OP_NEG_WORK;
		@(posedge clk);
		op_valid <= 1'b0;
		ce <= 1'b1;
		#1 chk("frozen done", {7'h00, op_done}, 8'h00);
		rd_chk("frozen work", ADDR_WORKING, 8'h55);
		// Reset in mid-run clears registers and RAM
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_chk("reset mid work", ADDR_WORKING, RST_BYTE);
		rd_chk("reset mid ram", 5'h12, RST_BYTE);
		rd_chk("reset mid flags", ADDR_FLAGS, {4'h0, RST_FLAGS});
		// Read-only and unmapped places
		wr_reg(ADDR_PIN, 8'hFF);
		rd_chk("pins ro", ADDR_PIN, 8'h00);
		rd_chk("unmapped", 5'h08, 8'h00);
		#1 chk("rdata idle", rdata, 8'h00);
		@(posedge clk);
		stop_test();
	end
endmodule // tb_complement_compare_bit_ops

`default_nettype wire
